// [hw/twi_pkg.sv]
package twi_pkg;
	localparam int          PORT_W        = 8;
	localparam logic [7:0]  TRAP_OPCODE   = 8'h00;
	localparam logic [7:0]  VEC_TRAP      = 8'hFE;
	localparam logic [7:0]  VEC_WAKE      = 8'hE2;
	localparam logic [7:0]  VEC_DEFAULT   = 8'hE0;
	localparam logic        PEND_RESET    = 1'b0;
	localparam logic [7:0]  WAKE_RESET    = 8'h00;
	localparam logic [7:0]  APB_BYTE_MASK = 8'hFF;
	// Register byte offsets
	localparam logic [11:0] REG_CTRL      = 12'h000;
	localparam logic [11:0] REG_WAKE_EN   = 12'h004;
	localparam logic [11:0] REG_WAKE_EDGE = 12'h008;
	localparam logic [11:0] REG_WAKE_PEND = 12'h00C;
	localparam logic [11:0] REG_STATUS    = 12'h010;
	// Control field positions
	localparam int          CTRL_GIE      = 0;
	localparam int          CTRL_PORT_EN  = 1;
	// Status field positions
	localparam int          ST_TRAP       = 0;
	localparam int          ST_IN_ISR     = 1;
	localparam int          ST_BOOT       = 2;
	localparam int          ST_LOWPWR     = 3;
	typedef enum logic [2:0] {
		TWI_RUN   = 3'b001,
		TWI_LOWPW = 3'b010,
		TWI_ISR   = 3'b100
	} twi_state_t;
endpackage

// [hw/twi_trap_wake_irq.sv]
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
// Functional notes
// [RULE1] Reset clears trap pending flag
// [RULE2] Trap raise sets trap pending flag
// [RULE3] Only clear instruction or reset clears
// [RULE4] Fetched opcode 00 raises trap
// [RULE5] Fetches beyond flash return zero
// [RULE6] Trap outranks every other source
// [RULE7] Trap keeps GLOBAL_IRQ_ENABLE; blocks others
// [RULE8] Trap routine accepts only trap
// [RULE9] Trap pushes its own opcode address
// [RULE10] Trap acknowledged without enable check
// [RULE11] Eight edge wake inputs, one vector
// [RULE12] Per-bit wake interrupt enable
// [RULE13] Per-bit rising/falling edge select
// [RULE14] Pending bits latch triggers
// [RULE15] Request needs GLOBAL_IRQ_ENABLE, port enable, pending
// [RULE16] Wake without irq resumes next instruction
// [RULE17] Wake with irq runs service first
// [RULE18] Maskable never preempts a running routine
// [RULE19] Boot ROM suppresses interrupts, keeps GLOBAL_IRQ_ENABLE
// [RULE20] Boot ROM drops repeat pending events
// [RULE21] Dispatch yields E0..FE low byte
// [RULE22] Wake inputs synchronised, pend in two; code sets pending on the second clock after the pin is sampled
module twi_trap_wake_irq #(
	parameter int PORT_W   = twi_pkg::PORT_W,
	parameter int FLASH_SZ = 8192
) (
	input  wire logic              i_sys_clk,        // Instruction clock
	input  wire logic              i_reset_n,        // Async reset, active low
	input  wire logic              psel,             // APB select
	input  wire logic              penable,          // APB enable
	input  wire logic              pwrite,           // APB direction
	input  wire logic [11:0]       paddr,            // APB byte address
	input  wire logic [31:0]       pwdata,           // APB write data
	output logic                   pready,           // APB ready
	output logic [31:0]            prdata,           // APB read data
	output logic                   pslverr,          // APB error
	input  wire logic [15:0]       i_fetch_addr,     // Program fetch address
	input  wire logic [7:0]        i_flash_data,     // Raw flash byte
	input  wire logic              i_fetch_load,     // Opcode loaded to instr reg
	output logic [7:0]             o_fetch_data,     // Fetched byte to core
	input  wire logic              i_clr_trap,       // Clear-pending instr executes
	input  wire logic              i_dispatch,       // Vector dispatch instr, 1st cycle
	input  wire logic              i_ret_irq,        // Return-from-interrupt executes
	input  wire logic              i_lowpwr_enter,   // Halt/idle entered
	input  wire logic              i_boot_rom,       // Executing from boot ROM
	input  wire logic [PORT_W-1:0] i_wake_pins,      // Wake port pins
	output logic                   o_trap_pending,   // Trap pending flag
	output logic                   o_irq_req,        // Interrupt request to core
	output logic                   o_trap_take,      // Take trap now, push own addr
	output logic [7:0]             o_vector_lo,      // Dispatch PC low byte
	output logic                   o_wake,           // Leave low-power mode
	output logic                   o_wake_to_isr     // Wake goes to service first
);

	logic [PORT_W-1:0] sync1, sync2, prev;
	logic [PORT_W-1:0] next_sync1, next_sync2, next_prev;
	logic [PORT_W-1:0] wake_en, wake_edge, wake_pend;
	logic [PORT_W-1:0] next_wake_en, next_wake_edge, next_wake_pend;
	logic              global_irq_enable, port_en, trap_pending;
	logic              next_gie, next_port_en, next_trap_pending;
	logic [7:0]        fetch_data, next_fetch_data;
	logic [7:0]        vector_lo, next_vector_lo;
	logic              irq_req, trap_take, wake, wake_to_isr;
	logic              next_irq_req, next_trap_take, next_wake, next_wake_to_isr;
	logic              rdy, err, next_rdy, next_err;
	logic [31:0]       rdata, next_rdata;
	twi_pkg::twi_state_t state, next_state;
	logic [PORT_W-1:0] edges, set_pend;
	logic [2:0]        armed, next_armed;
	logic              trap_fetch, wake_active, acc, wr;

	// Rising selected by 0, falling by 1
	function automatic logic [PORT_W-1:0] edge_hits(input logic [PORT_W-1:0] cur,
		input logic [PORT_W-1:0] old, input logic [PORT_W-1:0] sel);
		edge_hits = (cur & ~old & ~sel) | (~cur & old & sel); // [RULE13]
	endfunction

	always_comb begin
		next_fetch_data = (32'(i_fetch_addr) < 32'(FLASH_SZ)) ? i_flash_data : 8'h00; // [RULE5]
		next_sync1 = i_wake_pins;
		next_sync2 = sync1;
		next_prev  = sync2;
		next_armed = {armed[1:0], 1'b1};
	end

	assign trap_fetch  = i_fetch_load && (o_fetch_data == twi_pkg::TRAP_OPCODE); // [RULE4]
	// Held off until prev holds a real sample; a pin high at reset is no edge
	assign edges       = armed[2] ? edge_hits(sync2, prev, wake_edge) : '0; // [RULE22]
	// Boot ROM: an edge on an already pending bit is simply dropped
	assign set_pend    = edges;                                        // [RULE14] [RULE20]
	assign wake_active = |(wake_pend & wake_en);                       // [RULE12]
	assign acc         = psel && penable;
	assign wr          = acc && pwrite;

	always_comb begin
		next_gie          = global_irq_enable;
		next_port_en      = port_en;
		next_wake_en      = wake_en;
		next_wake_edge    = wake_edge;
		next_wake_pend    = wake_pend;
		next_trap_pending = trap_pending;
		next_rdy          = 1'b0;
		next_err          = 1'b0;
		next_rdata        = 32'h0000_0000;
		if (acc && !rdy) begin
			next_rdy = 1'b1;
			case (paddr)
				twi_pkg::REG_CTRL: begin
					next_rdata = {30'h0000_0000, port_en, global_irq_enable};
					if (wr) begin
						next_gie     = pwdata[twi_pkg::CTRL_GIE];
						next_port_en = pwdata[twi_pkg::CTRL_PORT_EN];
					end
				end
				twi_pkg::REG_WAKE_EN: begin
					next_rdata = {24'h00_0000, wake_en};
					if (wr) next_wake_en = pwdata[PORT_W-1:0];
				end
				twi_pkg::REG_WAKE_EDGE: begin
					next_rdata = {24'h00_0000, wake_edge};
					if (wr) next_wake_edge = pwdata[PORT_W-1:0];
				end
				twi_pkg::REG_WAKE_PEND: begin
					next_rdata = {24'h00_0000, wake_pend};
					// Write one to clear
					if (wr) next_wake_pend = wake_pend & ~pwdata[PORT_W-1:0];
				end
				twi_pkg::REG_STATUS: begin
					next_rdata = {28'h000_0000, state == twi_pkg::TWI_LOWPW, i_boot_rom,
						state == twi_pkg::TWI_ISR, trap_pending};
				end
				default: next_err = 1'b1;
			endcase
		end
		// Set wins over any clear in the same cycle
		next_wake_pend = next_wake_pend | set_pend;                  // [RULE14]
		if (i_clr_trap)
			next_trap_pending = 1'b0;                                // [RULE3]
		if (trap_fetch)
			next_trap_pending = 1'b1;                                // [RULE2]
	end

	always_comb begin
		next_state       = state;
		next_trap_take   = 1'b0;
		next_irq_req     = 1'b0;
		next_wake        = 1'b0;
		next_wake_to_isr = 1'b0;
		next_vector_lo   = vector_lo;
		// Trap: no enable check, GLOBAL_IRQ_ENABLE untouched, core pushes opcode address
		next_trap_take = trap_fetch;                                 // [RULE10] [RULE9] [RULE7]
		next_irq_req = !i_boot_rom && global_irq_enable && port_en && wake_active && !trap_pending
			&& state == twi_pkg::TWI_RUN;                            // [RULE15] [RULE18] [RULE19] [RULE8]
		if (i_dispatch) begin
			if (trap_pending)
				next_vector_lo = twi_pkg::VEC_TRAP;                  // [RULE6] [RULE21]
			else if (global_irq_enable && port_en && wake_active)
				next_vector_lo = twi_pkg::VEC_WAKE;                  // [RULE11]
			else
				next_vector_lo = twi_pkg::VEC_DEFAULT;               // [RULE21]
		end
		case (state)
			twi_pkg::TWI_RUN: begin
				if (i_lowpwr_enter)
					next_state = twi_pkg::TWI_LOWPW;
				else if (i_dispatch && !trap_pending && global_irq_enable && port_en && wake_active)
					next_state = twi_pkg::TWI_ISR;
			end
			twi_pkg::TWI_LOWPW: begin
				if (|set_pend) begin
					next_wake = 1'b1;
					// Irq enabled: service first, else resume next instr
					next_wake_to_isr = global_irq_enable && port_en && |(set_pend & wake_en); // [RULE16] [RULE17]
					next_state = twi_pkg::TWI_RUN;
				end
			end
			twi_pkg::TWI_ISR: begin
				if (i_ret_irq)
					next_state = twi_pkg::TWI_RUN;
			end
			default: next_state = twi_pkg::TWI_RUN;
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1        <= '0;
			armed        <= 3'h0;
			sync2        <= '0;
			prev         <= '0;
			global_irq_enable          <= 1'b0;
			port_en      <= 1'b0;
			wake_en      <= twi_pkg::WAKE_RESET;
			wake_edge    <= twi_pkg::WAKE_RESET;
			wake_pend    <= twi_pkg::WAKE_RESET;
			trap_pending <= twi_pkg::PEND_RESET;                     // [RULE1]
			fetch_data   <= 8'h00;
			vector_lo    <= twi_pkg::VEC_DEFAULT;
			irq_req      <= 1'b0;
			trap_take    <= 1'b0;
			wake         <= 1'b0;
			wake_to_isr  <= 1'b0;
			rdy          <= 1'b0;
			err          <= 1'b0;
			rdata        <= 32'h0000_0000;
			state        <= twi_pkg::TWI_RUN;
		end else begin
			sync1        <= next_sync1;                              // [RULE22]
			sync2        <= next_sync2;
			prev         <= next_prev;
			armed        <= next_armed;
			global_irq_enable          <= next_gie;
			port_en      <= next_port_en;
			wake_en      <= next_wake_en;
			wake_edge    <= next_wake_edge;
			wake_pend    <= next_wake_pend;
			trap_pending <= next_trap_pending;
			fetch_data   <= next_fetch_data;
			vector_lo    <= next_vector_lo;
			irq_req      <= next_irq_req;
			trap_take    <= next_trap_take;
			wake         <= next_wake;
			wake_to_isr  <= next_wake_to_isr;
			rdy          <= next_rdy;
			err          <= next_err;
			rdata        <= next_rdata;
			state        <= next_state;
		end
	end

	assign pready         = rdy;
	assign pslverr        = err;
	assign prdata         = rdata;
	assign o_fetch_data   = fetch_data;
	assign o_trap_pending = trap_pending;
	assign o_irq_req      = irq_req;
	assign o_trap_take    = trap_take;
	assign o_vector_lo    = vector_lo;
	assign o_wake         = wake;
	assign o_wake_to_isr  = wake_to_isr;

	property p_trap_set;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		trap_fetch |=> trap_pending;
	endproperty
	a_trap_set: assert property (p_trap_set) else $error("trap flag not set"); // [RULE2]

	property p_trap_hold;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		trap_pending && !i_clr_trap |=> trap_pending;
	endproperty
	a_trap_hold: assert property (p_trap_hold) else $error("trap flag lost"); // [RULE3]

	property p_trap_clear;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_clr_trap && !trap_fetch |=> !trap_pending;
	endproperty
	a_trap_clear: assert property (p_trap_clear) else $error("trap flag not cleared"); // [RULE3]

	property p_beyond_flash;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		32'(i_fetch_addr) >= 32'(FLASH_SZ) |=> o_fetch_data == 8'h00;
	endproperty
	a_beyond_flash: assert property (p_beyond_flash) else $error("stray fetch not zero"); // [RULE5]

	property p_trap_vec;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_dispatch && trap_pending |=> o_vector_lo == twi_pkg::VEC_TRAP;
	endproperty
	a_trap_vec: assert property (p_trap_vec) else $error("trap not top vector"); // [RULE6]

	property p_block;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		trap_pending || i_boot_rom |=> !o_irq_req;
	endproperty
	a_block: assert property (p_block) else $error("irq while blocked"); // [RULE8]

	property p_req_cond;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_irq_req |-> $past(global_irq_enable) && $past(port_en) && $past(wake_active);
	endproperty
	a_req_cond: assert property (p_req_cond) else $error("irq without enables"); // [RULE15]

	sequence s_edge;
		edges[0] && !wake_edge[0];
	endsequence
	property p_pend;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_edge |=> wake_pend[0];
	endproperty
	a_pend: assert property (p_pend) else $error("edge not latched"); // [RULE14]

	property p_take_now;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		trap_fetch |=> o_trap_take;
	endproperty
	a_take_now: assert property (p_take_now) else $error("trap take late"); // [RULE10]

	property p_gie_kept;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		trap_fetch && !wr |=> $stable(global_irq_enable);
	endproperty
	a_gie_kept: assert property (p_gie_kept) else $error("trap moved enable"); // [RULE7]

	property p_vec_wake;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_dispatch && !trap_pending && global_irq_enable && port_en && wake_active
			|=> o_vector_lo == twi_pkg::VEC_WAKE;
	endproperty
	a_vec_wake: assert property (p_vec_wake) else $error("wake vector wrong"); // [RULE11]

	property p_vec_none;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_dispatch && !trap_pending && !(global_irq_enable && port_en && wake_active)
			|=> o_vector_lo == twi_pkg::VEC_DEFAULT;
	endproperty
	a_vec_none: assert property (p_vec_none) else $error("default vector wrong"); // [RULE21]

	property p_isr_no_req;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		state == twi_pkg::TWI_ISR |=> !o_irq_req;
	endproperty
	a_isr_no_req: assert property (p_isr_no_req) else $error("irq inside service"); // [RULE18]

	property p_boot_gie;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		i_boot_rom && !wr |=> $stable(global_irq_enable);
	endproperty
	a_boot_gie: assert property (p_boot_gie) else $error("boot moved enable"); // [RULE19]

	property p_fall_latch;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		armed[2] && !sync2[1] && prev[1] && wake_edge[1] |=> wake_pend[1];
	endproperty
	a_fall_latch: assert property (p_fall_latch) else $error("fall not latched"); // [RULE13]

	property p_no_spurious;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!wake_pend[0] && !edges[0] |=> !wake_pend[0];
	endproperty
	a_no_spurious: assert property (p_no_spurious) else $error("pending without edge"); // [RULE14]

	sequence s_lowpw_hit;
		state == twi_pkg::TWI_LOWPW && |set_pend;
	endsequence
	property p_wake_isr;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_lowpw_hit ##0 (global_irq_enable && port_en && |(set_pend & wake_en)) |=> o_wake && o_wake_to_isr;
	endproperty
	a_wake_isr: assert property (p_wake_isr) else $error("wake skipped service"); // [RULE17]

	property p_wake_plain;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		s_lowpw_hit ##0 !(global_irq_enable && port_en) |=> o_wake && !o_wake_to_isr;
	endproperty
	a_wake_plain: assert property (p_wake_plain) else $error("wake took service"); // [RULE16]

	property p_wake_resume;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_wake |-> state == twi_pkg::TWI_RUN;
	endproperty
	a_wake_resume: assert property (p_wake_resume) else $error("wake did not resume"); // [RULE16]

	property p_req_when;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		!i_boot_rom && global_irq_enable && port_en && wake_active && !trap_pending
			&& state == twi_pkg::TWI_RUN |=> o_irq_req;
	endproperty
	a_req_when: assert property (p_req_when) else $error("irq not raised"); // [RULE15]

	property p_take_only_fetch;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		o_trap_take |-> $past(trap_fetch);
	endproperty
	a_take_only_fetch: assert property (p_take_only_fetch) else $error("stray trap take"); // [RULE4]

	property p_fetch_in_flash;
		@(posedge i_sys_clk) disable iff (!i_reset_n)
		32'(i_fetch_addr) < 32'(FLASH_SZ) |=> o_fetch_data == $past(i_flash_data);
	endproperty
	a_fetch_in_flash: assert property (p_fetch_in_flash) else $error("flash byte lost"); // [RULE5]

endmodule // twi_trap_wake_irq

// [tb/test_trap_and_wake_port_irq.sv]
`timescale 1ns/1ps
module test_trap_and_wake_port_irq;
	logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, tpend, irq, take, wake, w2isr;
	logic [15:0] faddr = 16'h0000, push;
	logic [7:0]  fdata, fout, vec, takes, wakes, iwakes, pins = 8'h00;
	logic        load = 1'h0, clr = 1'h0, disp = 1'h0, ret = 1'h0, lpe = 1'h0, boot = 1'h0;
	int          bad_count = 0, num_checks = 0;
	always #10 clk = ~clk;
	twi_trap_wake_irq #(.FLASH_SZ(256)) dut (
		.i_sys_clk(clk), .i_reset_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .i_fetch_addr(faddr),
		.i_flash_data(fdata), .i_fetch_load(load), .o_fetch_data(fout),
		.i_clr_trap(clr), .i_dispatch(disp), .i_ret_irq(ret),
		.i_lowpwr_enter(lpe), .i_boot_rom(boot), .i_wake_pins(pins),
		.o_trap_pending(tpend), .o_irq_req(irq), .o_trap_take(take),
		.o_vector_lo(vec), .o_wake(wake), .o_wake_to_isr(w2isr));
	twi_core_model core (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_fetch_addr(faddr),
		.o_flash_data(fdata), .i_trap_take(take), .i_wake(wake),
		.i_wake_to_isr(w2isr), .o_push_addr(push), .o_takes(takes),
		.o_wakes(wakes), .o_isr_wakes(iwakes));
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'h1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'h1;
		@(posedge clk);
		// No wait limit here; a stuck slave is ended by the watchdog
		while (pready !== 1'h1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask
	task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(nm, rd, exp);
	endtask
	task pulse(input int k);
		@(posedge clk);
		case (k)
			0: clr <= 1'h1;
			1: disp <= 1'h1;
			2: ret <= 1'h1;
			default: lpe <= 1'h1;
		endcase
		@(posedge clk);
		{clr, disp, ret, lpe} <= 4'h0;
	endtask
	task fetch(input logic [15:0] a, input logic [7:0] exp);
		@(posedge clk);
		faddr <= a;
		@(posedge clk);
		load <= 1'h1;
		@(posedge clk);
		load <= 1'h0;
		chk("fetch_data", fout, exp);
		cyc(2);
	endtask
	task pins_to(input logic [7:0] v);
		@(posedge clk);
		pins <= v;
		cyc(5);
	endtask
	task finish_test;
		$display("checks %0d errors %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		cyc(4);
		rst_n <= 1'h1;
		cyc(1);
		chk("trap_pending", tpend, 1'h0);
		chk("vector", vec, 8'hE0);
		for (int i = 0; i < 5; i++)
			rdc("reset_reg", 12'(4 * i), 32'h0);
		apb(1'h0, 12'h020, 32'h0);
		chk("unmapped_err", err, 1'h1);
		apb(1'h1, twi_pkg::REG_CTRL, 32'h3);
		apb(1'h1, twi_pkg::REG_WAKE_EN, 32'h0F);
		apb(1'h1, twi_pkg::REG_WAKE_EDGE, 32'h0A);
		rdc("wake_en", twi_pkg::REG_WAKE_EN, 32'h0F);
		rdc("wake_edge", twi_pkg::REG_WAKE_EDGE, 32'h0A);
		pins_to(8'hFF);
		rdc("pend_rise", twi_pkg::REG_WAKE_PEND, 32'hF5);
		chk("irq_req", irq, 1'h1);
		pins_to(8'h00);
		rdc("pend_fall", twi_pkg::REG_WAKE_PEND, 32'hFF);
		boot <= 1'h1;
		cyc(3);
		chk("boot_irq", irq, 1'h0);
		pins_to(8'hFF);
		rdc("boot_pend", twi_pkg::REG_WAKE_PEND, 32'hFF);
		rdc("boot_ctrl", twi_pkg::REG_CTRL, 32'h3);
		boot <= 1'h0;
		cyc(3);
		chk("after_boot_irq", irq, 1'h1);
		pulse(1);
		cyc(2);
		chk("vector_wake", vec, 8'hE2);
		chk("isr_irq", irq, 1'h0);
		fetch(16'h0105, 8'h00);
		chk("trap_set", tpend, 1'h1);
		chk("takes", takes, 8'h01);
		chk("push_addr", push, 16'h0105);
		rdc("trap_ctrl", twi_pkg::REG_CTRL, 32'h3);
		apb(1'h1, twi_pkg::REG_STATUS, 32'h0);
		rdc("status", twi_pkg::REG_STATUS, 32'h3);
		pulse(1);
		cyc(2);
		chk("vector_trap", vec, 8'hFE);
		pulse(2);
		cyc(3);
		chk("trap_blocks", irq, 1'h0);
		pulse(0);
		cyc(3);
		chk("trap_clr", tpend, 1'h0);
		chk("irq_back", irq, 1'h1);
		fetch(16'h0042, 8'h42);
		fetch(16'h0000, 8'h00);
		chk("takes_flash", takes, 8'h02);
		pulse(0);
		apb(1'h1, twi_pkg::REG_CTRL, 32'h2);
		cyc(2);
		chk("gie_off", irq, 1'h0);
		apb(1'h1, twi_pkg::REG_WAKE_PEND, 32'hFF);
		rdc("pend_w1c", twi_pkg::REG_WAKE_PEND, 32'h0);
		pulse(1);
		cyc(2);
		chk("vector_none", vec, 8'hE0);
		apb(1'h1, twi_pkg::REG_CTRL, 32'h1);
		pulse(3);
		pins_to(8'hFD);
		chk("wakes", wakes, 8'h01);
		chk("isr_wakes", iwakes, 8'h00);
		apb(1'h1, twi_pkg::REG_WAKE_PEND, 32'hFF);
		apb(1'h1, twi_pkg::REG_CTRL, 32'h3);
		pulse(3);
		pins_to(8'hF5);
		chk("wakes2", wakes, 8'h02);
		chk("isr_wakes2", iwakes, 8'h01);
		// Mid-run reset with a trap pending and pins held at F5
		fetch(16'h0000, 8'h00);
		chk("trap_again", tpend, 1'h1);
		rst_n <= 1'h0;
		cyc(2);
		rst_n <= 1'h1;
		cyc(1);
		chk("reset_trap", tpend, 1'h0);
		chk("reset_vector", vec, 8'hE0);
		cyc(4);
		rdc("reset_pend", twi_pkg::REG_WAKE_PEND, 32'h0);
		finish_test;
	end
	initial begin
		repeat (4000) @(posedge clk);
		bad_count++;
		finish_test;
	end
endmodule // test_trap_and_wake_port_irq

// [tb/twi_core_model.sv]
`timescale 1ns/1ps
module twi_core_model (
	input  wire logic        i_sys_clk,     // Instruction clock
	input  wire logic        i_reset_n,     // Async reset, active low
	input  wire logic [15:0] i_fetch_addr,  // Fetch address from core
	output logic      [7:0]  o_flash_data,  // Raw flash byte
	input  wire logic        i_trap_take,   // Trap entry pulse
	input  wire logic        i_wake,        // Wake pulse
	input  wire logic        i_wake_to_isr, // Wake goes to service
	output logic      [15:0] o_push_addr,   // Address pushed on trap
	output logic      [7:0]  o_takes,       // Trap entries seen
	output logic      [7:0]  o_wakes,       // Wakes seen
	output logic      [7:0]  o_isr_wakes    // Wakes into service
);
	// Low address byte as content, so address zero holds a trap opcode
	assign o_flash_data = i_fetch_addr[7:0];
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_takes <= 8'h00;
			o_wakes <= 8'h00;
			o_isr_wakes <= 8'h00;
			o_push_addr <= 16'h0000;
		end else begin
			if (i_trap_take) begin
				o_takes <= o_takes + 8'h01;
				o_push_addr <= i_fetch_addr;
			end
			if (i_wake)
				o_wakes <= o_wakes + 8'h01;
			if (i_wake && i_wake_to_isr)
				o_isr_wakes <= o_isr_wakes + 8'h01;
		end
	end
endmodule // twi_core_model
